// >>> logic/acr_top.sv
// Control and result logic for a 10-bit successive-approximation converter.
// Assumes the analog core returns its code on a pin bus from another domain
// and that the trigger source is already selected by logic on core_clk.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns

module acr_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [9:0] core_code,
  input wire logic trigger_in,
  input wire logic free_run_select,
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  output acr_pkg::acr_analog_t analog,
  output logic conv_irq_req,
  output logic irq
);
  import acr_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic [6:0] div_limit(input logic [2:0] code);
    logic [7:0] d;
    d = (code <= ACR_DIV_MIN_CODE) ? ACR_DIV_BASE : (8'h01 << code);
    return 7'(d - 8'h01);
  endfunction : div_limit

  acr_ctrl_t ctrl;
  acr_sel_t sel;
  acr_sel_t act;
  acr_state_t state;
  logic [9:0] code_s1;
  logic [9:0] code_s2;
  logic [9:0] result;
  logic [6:0] div_cnt;
  logic adc_tick;
  logic [4:0] cyc_cnt;
  logic [4:0] conv_len;
  logic init_due;
  logic trig_prev;
  logic start_pend;
  logic [ACR_EV_W-1:0] ev_stat;
  logic [ACR_EV_W-1:0] ev_mask;
  logic wr_ctrl;
  logic wr_sel;
  logic busy;
  logic trig_edge;
  logic last_cyc;
  logic conv_done;
  logic abort;
  logic sel_track;
  acr_ctrl_t wctrl;

  assign wctrl = acr_ctrl_t'(reg_wdata);
  assign wr_ctrl = reg_wr && reg_addr == ACR_OFS_CTRL;
  assign wr_sel = reg_wr && reg_addr == ACR_OFS_SEL;
  assign busy = state != ACR_IDLE;
  assign trig_edge = ctrl.auto_trig && trigger_in && !trig_prev;
  assign last_cyc = state == ACR_CONV && cyc_cnt == 5'(conv_len - 5'd1);
  assign conv_done = last_cyc && adc_tick;
  assign abort = wr_ctrl && !wctrl.enable && busy;
  assign sel_track = state != ACR_CONV || last_cyc;

  // ==========================================================================
  // Pin synchroniser for the core code
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_s1 <= ACR_CODE_ZERO;
      code_s2 <= ACR_CODE_ZERO;
    end else begin
      code_s1 <= core_code;
      code_s2 <= code_s1;
    end
  end

  // ==========================================================================
  // Prescaler
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      adc_tick <= 1'b0;
    end else if (!ctrl.enable) begin
      div_cnt <= '0;
      adc_tick <= 1'b0;
    end else if (div_cnt >= div_limit(ctrl.clk_div)) begin
      div_cnt <= '0;
      adc_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 7'd1;
      adc_tick <= 1'b0;
    end
  end

  // ==========================================================================
  // Control register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= acr_ctrl_t'(ACR_RST_BYTE);
    end else begin
      if (wr_ctrl) begin
        ctrl.enable <= wctrl.enable;
        ctrl.auto_trig <= wctrl.auto_trig;
        ctrl.irq_en <= wctrl.irq_en;
        ctrl.clk_div <= wctrl.clk_div;
      end
      ctrl.start <= 1'b0;
      if (conv_done) begin
        ctrl.done_flag <= 1'b1;
      end else if ((wr_ctrl && wctrl.done_flag) || irq_vector_ack) begin
        ctrl.done_flag <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Selection register and its buffered copy
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel <= acr_sel_t'(ACR_RST_BYTE);
    end else if (wr_sel) begin
      sel <= acr_sel_t'(reg_wdata);
      sel.unused <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      act <= acr_sel_t'(ACR_RST_BYTE);
    end else if (sel_track) begin
      act <= sel;
    end
  end

  // ==========================================================================
  // Conversion sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trigger_in;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_due <= 1'b0;
    end else if (wr_ctrl && wctrl.enable && !ctrl.enable) begin
      init_due <= 1'b1;
    end else if (state == ACR_WAIT && adc_tick) begin
      init_due <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_pend <= 1'b0;
    end else if (!ctrl.enable || state != ACR_IDLE) begin
      start_pend <= 1'b0;
    end else begin
      start_pend <= trig_edge;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ACR_IDLE;
      cyc_cnt <= '0;
      conv_len <= ACR_NORMAL_CYCLES;
    end else begin
      case (state)
        ACR_IDLE: begin
          if (wr_ctrl && wctrl.start && wctrl.enable) begin
            state <= ACR_WAIT;
          end else if (ctrl.enable && (trig_edge || start_pend)) begin
            state <= ACR_WAIT;
          end
        end
        ACR_WAIT: begin
          if (abort) begin
            state <= ACR_IDLE;
          end else if (adc_tick) begin
            state <= ACR_CONV;
            cyc_cnt <= '0;
            conv_len <= init_due ? ACR_FIRST_CYCLES
                                 : ACR_NORMAL_CYCLES;
          end
        end
        ACR_CONV: begin
          if (abort) begin
            state <= ACR_IDLE;
          end else if (conv_done) begin
            state <= (ctrl.auto_trig && free_run_select) ? ACR_WAIT
                                                         : ACR_IDLE;
          end else if (adc_tick) begin
            cyc_cnt <= cyc_cnt + 5'd1;
          end
        end
        default: begin
          state <= ACR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Result capture
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= ACR_CODE_ZERO;
    end else if (conv_done) begin
      result <= code_s2;
    end
  end

  // ==========================================================================
  // Analog side controls
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog <= '0;
    end else begin
      analog.ref_sel <= act.ref_sel;
      analog.chan <= act.chan;
      analog.temp_sensor_en <= act.chan == ACR_CH_TEMP;
      analog.int_ref_en <= act.ref_sel == ACR_REF_INT;
      analog.supply_ref_en <= act.ref_sel == ACR_REF_SUPPLY;
      analog.bandgap_en <= act.chan == ACR_CH_BANDGAP;
      analog.ground_en <= act.chan == ACR_CH_GROUND;
      analog.converting <= state == ACR_CONV && ctrl.enable;
    end
  end

  // ==========================================================================
  // Event status, mask and interrupt outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_stat <= '0;
      ev_mask <= '0;
    end else begin
      if (reg_wr && reg_addr == ACR_OFS_EV_MASK) begin
        ev_mask <= reg_wdata[ACR_EV_W-1:0];
      end
      for (int i = 0; i < ACR_EV_W; i++) begin
        if ((i == ACR_EV_DONE && conv_done) || (i == ACR_EV_ABORT && abort)) begin
          ev_stat[i] <= 1'b1;
        end else if (reg_wr && reg_addr == ACR_OFS_EV_STAT && reg_wdata[i]) begin
          ev_stat[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
      conv_irq_req <= 1'b0;
    end else begin
      irq <= |(ev_stat & ev_mask);
      conv_irq_req <= ctrl.done_flag && ctrl.irq_en
                      && global_irq_enable;
    end
  end

  // ==========================================================================
  // Register read port
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= ACR_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        ACR_OFS_CTRL: begin
          reg_rdata <= {ctrl.enable, busy, ctrl.auto_trig, ctrl.done_flag,
                        ctrl.irq_en, ctrl.clk_div};
        end
        ACR_OFS_SEL: begin
          reg_rdata <= {sel.ref_sel, sel.left_align, 1'b0, sel.chan};
        end
        ACR_OFS_RES_LOW: begin
          reg_rdata <= sel.left_align ? {result[1:0], 6'h00}
                                      : result[7:0];
        end
        ACR_OFS_RES_HIGH: begin
          reg_rdata <= sel.left_align ? result[9:2]
                                      : {6'h00, result[9:8]};
        end
        ACR_OFS_EV_STAT: begin
          reg_rdata <= {{(8-ACR_EV_W){1'b0}}, ev_stat};
        end
        ACR_OFS_EV_MASK: begin
          reg_rdata <= {{(8-ACR_EV_W){1'b0}}, ev_mask};
        end
        default: begin
          reg_rdata <= ACR_RST_BYTE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Assertions
  property p_bit4_zero;
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == ACR_OFS_SEL |=> reg_rdata[4] == 1'b0;
  endproperty
  a_bit4_zero: assert property (p_bit4_zero)
    else $error("selection bit 4 read nonzero");

  property p_conv_len;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(state == ACR_CONV) |-> conv_len == ($past(init_due)
      ? ACR_FIRST_CYCLES : ACR_NORMAL_CYCLES);
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");

  property p_done_flag;
    @(posedge core_clk) disable iff (!rst_n)
    conv_done |=> ctrl.done_flag && result == $past(code_s2);
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("done flag or result not updated");

  property p_abort;
    @(posedge core_clk) disable iff (!rst_n)
    abort |=> state == ACR_IDLE ##1 !analog.converting;
  endproperty
  a_abort: assert property (p_abort)
    else $error("disable did not abort conversion");

  property p_busy_read;
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == ACR_OFS_CTRL |=> reg_rdata[6] == $past(busy);
  endproperty
  a_busy_read: assert property (p_busy_read)
    else $error("start bit does not show busy");

  property p_sel_locked;
    @(posedge core_clk) disable iff (!rst_n)
    state == ACR_CONV && !last_cyc && !abort |=> $stable(act);
  endproperty
  a_sel_locked: assert property (p_sel_locked)
    else $error("selection changed during conversion");

  property p_irq_req;
    @(posedge core_clk) disable iff (!rst_n)
    ctrl.done_flag && ctrl.irq_en && global_irq_enable |=> conv_irq_req;
  endproperty
  a_irq_req: assert property (p_irq_req)
    else $error("interrupt request missing");

  property p_left_high;
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == ACR_OFS_RES_HIGH && sel.left_align
      |=> reg_rdata == $past(result[9:2]);
  endproperty
  a_left_high: assert property (p_left_high)
    else $error("left adjusted high byte wrong");

  property p_tick_gap;
    @(posedge core_clk) disable iff (!rst_n)
    adc_tick && ctrl.enable && $stable(ctrl.clk_div) |=> !adc_tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("converter clock faster than half rate");

  c_first: cover property (@(posedge core_clk) disable iff (!rst_n)
    conv_done && conv_len == ACR_FIRST_CYCLES);
  c_trig: cover property (@(posedge core_clk) disable iff (!rst_n)
    trig_edge && state == ACR_IDLE);
  c_abort: cover property (@(posedge core_clk) disable iff (!rst_n)
    abort);

endmodule : acr_top

// >>> logic/acr_pkg.sv
// Constants, register map and field layouts of the converter control block.
// Assumes a byte-wide register port and a single 10 MHz core clock.
package acr_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ACR_OFS_RES_LOW = 8'h78;
  localparam logic [7:0] ACR_OFS_RES_HIGH = 8'h79;
  localparam logic [7:0] ACR_OFS_CTRL = 8'h7A;
  localparam logic [7:0] ACR_OFS_SEL = 8'h7C;
  localparam logic [7:0] ACR_OFS_EV_STAT = 8'h7E;
  localparam logic [7:0] ACR_OFS_EV_MASK = 8'h7F;

  // ==========================================================================
  // Reset values and field codes
  localparam logic [7:0] ACR_RST_BYTE = 8'h00;
  localparam logic [1:0] ACR_REF_EXT = 2'h0;
  localparam logic [1:0] ACR_REF_SUPPLY = 2'h1;
  localparam logic [1:0] ACR_REF_INT = 2'h3;
  localparam logic [3:0] ACR_CH_LAST_PIN = 4'h7;
  localparam logic [3:0] ACR_CH_TEMP = 4'h8;
  localparam logic [3:0] ACR_CH_BANDGAP = 4'hE;
  localparam logic [3:0] ACR_CH_GROUND = 4'hF;
  localparam logic [2:0] ACR_DIV_MIN_CODE = 3'h1;
  localparam logic [7:0] ACR_DIV_BASE = 8'h02;
  localparam logic [9:0] ACR_CODE_ZERO = 10'h000;

  // ==========================================================================
  // Conversion lengths in converter clock cycles
  localparam logic [4:0] ACR_FIRST_CYCLES = 5'd25;
  localparam logic [4:0] ACR_NORMAL_CYCLES = 5'd13;

  // ==========================================================================
  // Event status bits
  localparam int ACR_EV_W = 2;
  localparam int ACR_EV_DONE = 0;
  localparam int ACR_EV_ABORT = 1;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic enable;
    logic start;
    logic auto_trig;
    logic done_flag;
    logic irq_en;
    logic [2:0] clk_div;
  } acr_ctrl_t;

  typedef struct packed {
    logic [1:0] ref_sel;
    logic left_align;
    logic unused;
    logic [3:0] chan;
  } acr_sel_t;

  typedef struct packed {
    logic [1:0] ref_sel;
    logic [3:0] chan;
    logic temp_sensor_en;
    logic int_ref_en;
    logic supply_ref_en;
    logic bandgap_en;
    logic ground_en;
    logic converting;
  } acr_analog_t;

  typedef enum logic [2:0] {
    ACR_IDLE = 3'b001,
    ACR_WAIT = 3'b010,
    ACR_CONV = 3'b100
  } acr_state_t;

endpackage : acr_pkg

// >>> sim/acr_core_model.sv
// Behavioural analog core and input multiplexer facing the control block.
// Assumes the analog struct arrives registered on core_clk.
`timescale 1ns/1ns
module acr_core_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire acr_pkg::acr_analog_t analog,
  input wire logic [9:0] vin,
  output logic [9:0] core_code
);
  import acr_pkg::*;
  // ==========================================================================
  // Sample and hold
  logic conv_q;
  logic [2:0] hold;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_q <= 1'b0;
      hold <= 3'h0;
      core_code <= ACR_CODE_ZERO;
    end else begin
      conv_q <= analog.converting;
      if (analog.converting && !conv_q) begin
        core_code <= (analog.chan == ACR_CH_GROUND) ? ACR_CODE_ZERO :
          vin + {6'h00, analog.chan};
        hold <= 3'h4;
      end else if (analog.converting) begin
        hold <= 3'h4;
      end else if (hold != 3'h0) begin
        hold <= hold - 3'h1;
      end else begin
        core_code <= ~core_code;
      end
    end
  end
endmodule : acr_core_model

// >>> sim/tb_acr_top.sv
// Self-checking bench of the converter control block.
// Assumes the analog core model and a 10 MHz core clock.
`timescale 1ns/1ns
module tb_acr_top;
  import acr_pkg::*;
  // ==========================================================================
  // Signals
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [9:0] core_code;
  logic [9:0] vin = 10'h000;
  logic trigger_in = 1'b0;
  logic free_run_select = 1'b0;
  logic global_irq_enable = 1'b1;
  logic irq_vector_ack = 1'b0;
  acr_analog_t analog;
  logic conv_irq_req;
  logic irq;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [15:0] lf = 16'h38D6;
  logic [7:0] ctl = 8'h00;
  logic [7:0] v;
  logic [1:0] r;
  logic [3:0] ch;
  logic [7:0] rst_addr [7] = '{8'h78, 8'h79, 8'h7A, 8'h7C, 8'h7E, 8'h7F,
                               8'h7B};

  always #50 core_clk = ~core_clk;

  acr_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_code(core_code), .trigger_in(trigger_in),
    .free_run_select(free_run_select),
    .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack),
    .analog(analog), .conv_irq_req(conv_irq_req), .irq(irq));

  acr_core_model core_u (.core_clk(core_clk), .rst_n(rst_n),
    .analog(analog), .vin(vin), .core_code(core_code));

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic [9:0] exp_code(input logic [3:0] c,
                                          input logic [9:0] x);
    return (c == 4'hF) ? 10'h000 : x + {6'h00, c};
  endfunction : exp_code

  task automatic end_sim;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [11:0] e,
                     input logic [11:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic chk_rng(input string what, input int lo, input int hi,
                         input int g);
    tests_run++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, g);
    end
  endtask : chk_rng

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd_reg

  task automatic conv_start(input logic [2:0] dc);
    logic [7:0] b;
    ctl = {5'b11001, dc};
    wr_reg(ACR_OFS_CTRL, ctl);
    rd_reg(ACR_OFS_CTRL, b);
    chk("busy", {4'h0, ctl}, {4'h0, b});
  endtask : conv_start

  task automatic conv_end(input int len, input logic [2:0] dc,
                          input logic [3:0] c, input logic la,
                          input logic ack);
    int d;
    int n;
    logic [7:0] b;
    logic [9:0] e;
    d = (dc < 3'h2) ? 2 : (1 << dc);
    n = 0;
    while (conv_irq_req !== 1'b1 && n < 30 * d + 20) begin
      @(negedge core_clk);
      n++;
    end
    if (len > 0) chk_rng("cycles", len * d - 4, len * d + d + 4, n);
    e = exp_code(c, vin);
    rd_reg(ACR_OFS_RES_LOW, b);
    chk("res low", la ? {4'h0, e[1:0], 6'h00} : {4'h0, e[7:0]}, {4'h0, b});
    rd_reg(ACR_OFS_RES_HIGH, b);
    chk("res high", la ? {4'h0, e[9:2]} : {10'h000, e[9:8]}, {4'h0, b});
    if (ack) begin
      global_irq_enable <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk("irq req", 12'h000, {11'h000, conv_irq_req});
      irq_vector_ack <= 1'b1;
      global_irq_enable <= 1'b1;
      @(posedge core_clk);
      irq_vector_ack <= 1'b0;
    end else wr_reg(ACR_OFS_CTRL, (ctl & 8'hAF) | 8'h10);
    rd_reg(ACR_OFS_CTRL, b);
    if (!ctl[5]) chk("ctrl", {4'h0, ctl & 8'hAF}, {4'h0, b});
  endtask : conv_end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      end_sim();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    wr_reg(8'h7B, 8'hFF);
    for (int i = 0; i < 7; i++) begin
      rd_reg(rst_addr[i], v);
      chk("reset value", 12'h000, {4'h0, v});
    end
    for (int i = 0; i < 16; i++) begin
      if (i > 8 && i < 14) continue;
      lf = lfsr_next(lf);
      r = (lf[1:0] == 2'h2) ? 2'h3 : lf[1:0];
      wr_reg(ACR_OFS_SEL, {r, lf[2], lf[3], i[3:0]});
      rd_reg(ACR_OFS_SEL, v);
      chk("select", {4'h0, r, lf[2], 1'b0, i[3:0]}, {4'h0, v});
      chk("decode", {r, i[3:0], i == 8, r == 2'h3, r == 2'h1, i == 14,
        i == 15, 1'b0}, analog);
    end
    wr_reg(ACR_OFS_CTRL, 8'h40);
    rd_reg(ACR_OFS_CTRL, v);
    chk("start off", 12'h000, {4'h0, v});
    wr_reg(ACR_OFS_EV_MASK, 8'h01);
    vin <= 10'h1A5;
    wr_reg(ACR_OFS_SEL, 8'hC8);
    conv_start(3'h0);
    conv_end(25, 3'h0, 4'h8, 1'b0, 1'b1);
    chk("irq", 12'h001, {11'h000, irq});
    wr_reg(ACR_OFS_EV_MASK, 8'h00);
    @(posedge core_clk);
    #1 chk("irq masked", 12'h000, {11'h000, irq});
    wr_reg(ACR_OFS_EV_MASK, 8'h01);
    wr_reg(ACR_OFS_EV_STAT, 8'h03);
    @(posedge core_clk);
    #1 chk("irq clear", 12'h000, {11'h000, irq});
    vin <= 10'h3FF;
    wr_reg(ACR_OFS_SEL, 8'h4F);
    conv_start(3'h1);
    conv_end(13, 3'h1, 4'hF, 1'b0, 1'b0);
    wr_reg(ACR_OFS_SEL, 8'h40);
    conv_start(3'h2);
    conv_end(13, 3'h2, 4'h0, 1'b0, 1'b0);
    vin <= 10'h2D3;
    wr_reg(ACR_OFS_SEL, 8'h45);
    conv_start(3'h2);
    wr_reg(ACR_OFS_SEL, 8'h66);
    rd_reg(ACR_OFS_RES_LOW, v);
    chk("left low", 12'h0C0, {4'h0, v});
    rd_reg(ACR_OFS_RES_HIGH, v);
    chk("left high", 12'h0FF, {4'h0, v});
    chk("held chan", 12'h005, {8'h00, analog.chan});
    conv_end(13, 3'h2, 4'h5, 1'b1, 1'b0);
    chk("new chan", 12'h006, {8'h00, analog.chan});
    conv_start(3'h0);
    repeat (6) @(posedge core_clk);
    wr_reg(ACR_OFS_CTRL, 8'h00);
    repeat (60) @(posedge core_clk);
    rd_reg(ACR_OFS_CTRL, v);
    chk("abort ctrl", 12'h000, {4'h0, v});
    rd_reg(ACR_OFS_EV_STAT, v);
    chk("abort event", 12'h003, {4'h0, v});
    wr_reg(ACR_OFS_EV_STAT, 8'h03);
    wr_reg(ACR_OFS_SEL, 8'h46);
    conv_start(3'h3);
    conv_end(25, 3'h3, 4'h6, 1'b0, 1'b0);
    for (int k = 0; k < 8; k++) begin
      lf = lfsr_next(lf);
      ch = (lf[3:0] > 4'h8 && lf[3:0] < 4'hE) ? {1'b0, lf[2:0]} : lf[3:0];
      vin <= lf[15:6];
      r = (ch == ACR_CH_TEMP) ? ACR_REF_INT : ACR_REF_SUPPLY;
      wr_reg(ACR_OFS_SEL, {r, 2'h0, ch});
      conv_start(k[2:0]);
      conv_end(13, k[2:0], ch, 1'b0, 1'b0);
    end
    ctl = 8'h89;
    wr_reg(ACR_OFS_CTRL, ctl);
    trigger_in <= 1'b1;
    repeat (60) @(posedge core_clk);
    rd_reg(ACR_OFS_CTRL, v);
    chk("no trigger", {4'h0, ctl}, {4'h0, v});
    trigger_in <= 1'b0;
    free_run_select <= 1'b1;
    ctl = 8'hA9;
    wr_reg(ACR_OFS_CTRL, ctl);
    trigger_in <= 1'b1;
    conv_end(13, 3'h1, ch, 1'b0, 1'b0);
    conv_end(0, 3'h1, ch, 1'b0, 1'b0);
    free_run_select <= 1'b0;
    wr_reg(ACR_OFS_CTRL, 8'h00);
    end_sim();
  end
endmodule : tb_acr_top
